// *** verilog/clockgen_defines.svh ***
// constants for the serial configuration port and control pins
// assumes a single 25 MHz clock and synchronous pin inputs
`ifndef CLOCKGEN_DEFINES_SVH
`define CLOCKGEN_DEFINES_SVH

// ****************************************
// clock and timing
// ****************************************
`define CG_CLK_PERIOD_NS 40
`define CG_STEP_MIN_NS 100
`define CG_STEP_MIN_CYC \
    ((`CG_STEP_MIN_NS + `CG_CLK_PERIOD_NS - 1) / `CG_CLK_PERIOD_NS)
`define CG_TIMEOUT_US 25000
`define CG_TIMEOUT_CYC ((`CG_TIMEOUT_US * 1000) / `CG_CLK_PERIOD_NS)

// ****************************************
// addressing and register space
// ****************************************
`define CG_ADDR_FIXED 6'h38
`define CG_REG_LOWVOLT 8'h1b
`define CG_LOWVOLT_BIT 7
`define CG_REG_COUNT 256

`endif

// *** verilog/clockgen_pkg.sv ***
// types shared by the serial port and control pin logic
// assumes the defines header is compiled alongside
package clockgen_pkg;

    // ****************************************
    // variant of the two multi-function pins
    // ****************************************
    typedef enum logic [1:0] {
        VAR_CLKIN = 2'h0,
        VAR_PHASE = 2'h1,
        VAR_FREQ = 2'h2,
        VAR_OUTDIS = 2'h3
    } variant_t;

    // ****************************************
    // serial slave states, one-hot
    // ****************************************
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_ADDR = 7'h02,
        ST_ACK_ADDR = 7'h04,
        ST_WRITE = 7'h08,
        ST_ACK_WR = 7'h10,
        ST_READ = 7'h20,
        ST_ACK_RD = 7'h40
    } slave_state_t;

    typedef struct packed {
        logic enable;
        logic highZ;
    } clk_ctrl_t;

    typedef struct packed {
        logic up;
        logic down;
    } step_t;

endpackage

// *** verilog/step_pulse_filter.sv ***
// qualifies one step pin: one-cycle pulse once the pin has been high
// for the minimum width; assumes the pin is synchronous to mclk
`timescale 1ns/1ps
`include "clockgen_defines.svh"

module step_pulse_filter (
    input wire logic mclk,
    input wire logic srst,
    input wire logic pin,
    output logic pulse
);
    localparam logic [2:0] MIN_CYC = 3'(`CG_STEP_MIN_CYC);

    logic [2:0] highCnt;
    wire reached = (highCnt == MIN_CYC - 3'h1) & pin;

    // [RULE_06] minimum width qualify
    // [RULE_07] minimum width qualify
    always_ff @(posedge mclk) begin
        if (srst || !pin) begin
            highCnt <= 3'h0;
            pulse <= 1'b0;
        end else begin
            if (highCnt != MIN_CYC) begin
                highCnt <= highCnt + 3'h1;
            end
            pulse <= reached;
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (srst);

    property p_minWidth;
        $rose(pulse) |-> $past(pin, 1) && $past(pin, 2) && $past(pin, 3);
    endproperty
    a_minWidth: assert property (p_minWidth) // [RULE_06]
        else $error("step pulse before minimum width");

    property p_single;
        pulse |=> !pulse;
    endproperty
    a_single: assert property (p_single) // [RULE_07]
        else $error("step pulse longer than one cycle");
endmodule

// *** verilog/clockgen_serial_ctrl.sv ***
// serial configuration slave with register space and control pins
// assumes scl and sda are synchronous to mclk, sda is open drain
`timescale 1ns/1ps
`include "clockgen_defines.svh"

// Notes on behaviour
// [RULE_01] release stuck data line after timeout
// [RULE_02] host sets low-voltage bit below 2.5 V
// [RULE_03] answer 70h or 71h per address pin
// [RULE_04] output-disable pin high disables all outputs
// [RULE_05] disabled outputs high impedance by default
// [RULE_06] phase step pins, pulse at least 100 ns
// [RULE_07] frequency step pins, pulse at least 100 ns
// [RULE_08] 7-bit slave only, burst auto increment
// [RULE_09] write: address, pointer, then data bytes
// [RULE_10] read: set pointer, then read from it
// [RULE_11] fixed six bits plus pin, ignore others
module clockgen_serial_ctrl #(
    parameter int TIMEOUT_CYCLES = `CG_TIMEOUT_CYC
) (
    input wire logic mclk,
    input wire logic srst,
    input clockgen_pkg::variant_t variantSel,
    input wire logic multiFunctionInputA,
    input wire logic multiFunctionInputB,
    input wire logic driveLowWhenOff,
    input wire logic scl,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    output clockgen_pkg::clk_ctrl_t clkCtrl,
    output clockgen_pkg::step_t phaseStep,
    output clockgen_pkg::step_t freqStep,
    output logic lowVoltMode
);
    // ****************************************
    // bus sampling and conditions
    // ****************************************
    logic sclQ, sdaQ, sclPrev, sdaPrev;
    clockgen_pkg::slave_state_t state;
    logic [3:0] bitCnt;
    logic [7:0] rxShift, txShift, ptr;
    logic rnw, ptrPending, masterAck, slaveLsb;
    logic [19:0] sclLowCnt;
    logic [7:0] mem [`CG_REG_COUNT];

    wire sclRise = sclQ & ~sclPrev;
    wire sclFall = ~sclQ & sclPrev;
    wire startCond = sclQ & sclPrev & sdaPrev & ~sdaQ;
    wire stopCond = sclQ & sclPrev & ~sdaPrev & sdaQ;
    wire byteDone = bitCnt == 4'h8;
    wire [6:0] slaveAddr = {`CG_ADDR_FIXED, slaveLsb};
    wire addrMatch = rxShift[7:1] == slaveAddr;
    wire isIdle = state == clockgen_pkg::ST_IDLE;
    wire timedOut = !isIdle && (sclLowCnt == 20'(TIMEOUT_CYCLES));
    wire memWe = (state == clockgen_pkg::ST_WRITE) && sclFall &&
        byteDone && !ptrPending;
    wire [7:0] memRdata = mem[ptr];
    wire [7:0] ptrNext = ptr + 8'h01;

    always_ff @(posedge mclk) begin
        if (srst) begin
            sclQ <= 1'b1;
            sdaQ <= 1'b1;
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
        end else begin
            sclQ <= scl;
            sdaQ <= sdaIn;
            sclPrev <= sclQ;
            sdaPrev <= sdaQ;
        end
    end

    // [RULE_01] scl low watchdog
    always_ff @(posedge mclk) begin
        if (srst || sclQ || isIdle) begin
            sclLowCnt <= 20'h0;
        end else if (!timedOut) begin
            sclLowCnt <= sclLowCnt + 20'h1;
        end
    end

    // ****************************************
    // slave state machine
    // ****************************************
    always_ff @(posedge mclk) begin
        if (srst) begin
            state <= clockgen_pkg::ST_IDLE;
            bitCnt <= 4'h0;
            rxShift <= 8'h0;
            txShift <= 8'h0;
            rnw <= 1'b0;
            ptr <= 8'h0;
            ptrPending <= 1'b0;
            masterAck <= 1'b0;
            sdaOe <= 1'b0;
        end else if (timedOut || stopCond) begin
            // [RULE_01] release on timeout
            state <= clockgen_pkg::ST_IDLE;
            sdaOe <= 1'b0;
        end else if (startCond) begin
            state <= clockgen_pkg::ST_ADDR;
            bitCnt <= 4'h0;
            sdaOe <= 1'b0;
        end else begin
            case (state)
                clockgen_pkg::ST_ADDR, clockgen_pkg::ST_WRITE: begin
                    if (sclRise) begin
                        rxShift <= {rxShift[6:0], sdaQ};
                        bitCnt <= bitCnt + 4'h1;
                    end else if (sclFall && byteDone) begin
                        if (state == clockgen_pkg::ST_ADDR) begin
                            // [RULE_11] address compare
                            if (addrMatch) begin
                                state <= clockgen_pkg::ST_ACK_ADDR;
                                sdaOe <= 1'b1;
                                rnw <= rxShift[0];
                            end else begin
                                state <= clockgen_pkg::ST_IDLE;
                            end
                        end else begin
                            // [RULE_09] pointer then data
                            state <= clockgen_pkg::ST_ACK_WR;
                            sdaOe <= 1'b1;
                            ptrPending <= 1'b0;
                            ptr <= ptrPending ? rxShift : ptrNext;
                        end
                    end
                end
                clockgen_pkg::ST_ACK_ADDR: begin
                    if (sclFall) begin
                        bitCnt <= 4'h0;
                        if (rnw) begin
                            // [RULE_10] read from pointer
                            state <= clockgen_pkg::ST_READ;
                            txShift <= memRdata;
                            sdaOe <= ~memRdata[7];
                            ptr <= ptrNext;
                        end else begin
                            state <= clockgen_pkg::ST_WRITE;
                            sdaOe <= 1'b0;
                            ptrPending <= 1'b1;
                        end
                    end
                end
                clockgen_pkg::ST_ACK_WR: begin
                    if (sclFall) begin
                        state <= clockgen_pkg::ST_WRITE;
                        sdaOe <= 1'b0;
                        bitCnt <= 4'h0;
                    end
                end
                clockgen_pkg::ST_READ: begin
                    if (sclRise) begin
                        bitCnt <= bitCnt + 4'h1;
                    end else if (sclFall) begin
                        if (byteDone) begin
                            state <= clockgen_pkg::ST_ACK_RD;
                            sdaOe <= 1'b0;
                        end else begin
                            txShift <= {txShift[6:0], 1'b0};
                            sdaOe <= ~txShift[6];
                        end
                    end
                end
                clockgen_pkg::ST_ACK_RD: begin
                    if (sclRise) begin
                        masterAck <= ~sdaQ;
                    end else if (sclFall) begin
                        bitCnt <= 4'h0;
                        // [RULE_08] burst read increment
                        if (masterAck) begin
                            state <= clockgen_pkg::ST_READ;
                            txShift <= memRdata;
                            sdaOe <= ~memRdata[7];
                            ptr <= ptrNext;
                        end else begin
                            state <= clockgen_pkg::ST_IDLE;
                        end
                    end
                end
                default: begin
                    state <= clockgen_pkg::ST_IDLE;
                    sdaOe <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************
    // register space
    // ****************************************
    always_ff @(posedge mclk) begin
        if (srst) begin
            for (int i = 0; i < `CG_REG_COUNT; i++) begin
                mem[i] <= 8'h00;
            end
        end else if (memWe) begin
            mem[ptr] <= rxShift;
        end
    end

    // [RULE_02] low-voltage compatibility bit
    always_ff @(posedge mclk) begin
        if (srst) begin
            lowVoltMode <= 1'b0;
        end else if (memWe && ptr == `CG_REG_LOWVOLT) begin
            lowVoltMode <= rxShift[`CG_LOWVOLT_BIT];
        end
    end

    // ****************************************
    // control pins
    // ****************************************
    wire useLsb = (variantSel == clockgen_pkg::VAR_CLKIN) ||
        (variantSel == clockgen_pkg::VAR_OUTDIS);
    wire outDisable = (variantSel == clockgen_pkg::VAR_OUTDIS) &&
        multiFunctionInputA;
    wire isPhase = variantSel == clockgen_pkg::VAR_PHASE;
    wire isFreq = variantSel == clockgen_pkg::VAR_FREQ;
    wire [1:0] stepRaw = {multiFunctionInputB, multiFunctionInputA};
    wire [1:0] stepPulse;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_step
            step_pulse_filter u_filter (
                .mclk(mclk),
                .srst(srst),
                .pin(stepRaw[g]),
                .pulse(stepPulse[g])
            );
        end
    endgenerate

    always_ff @(posedge mclk) begin
        if (srst) begin
            slaveLsb <= 1'b0;
            clkCtrl <= '{enable: 1'b1, highZ: 1'b0};
            phaseStep <= '0;
            freqStep <= '0;
            sdaOut <= 1'b0;
        end else begin
            // [RULE_03] address low bit
            slaveLsb <= useLsb & multiFunctionInputB;
            // [RULE_04] disable all outputs
            clkCtrl.enable <= ~outDisable;
            // [RULE_05] tri-state when off
            clkCtrl.highZ <= outDisable & ~driveLowWhenOff;
            // [RULE_06] phase step routing
            phaseStep <= '{up: isPhase & stepPulse[0],
                down: isPhase & stepPulse[1]};
            // [RULE_07] frequency step routing
            freqStep <= '{up: isFreq & stepPulse[0],
                down: isFreq & stepPulse[1]};
            sdaOut <= 1'b0;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);

    property p_timeout;
        timedOut |=> isIdle && !sdaOe;
    endproperty
    a_timeout: assert property (p_timeout) // [RULE_01]
        else $error("timeout did not release the bus");

    property p_addrAck;
        state == clockgen_pkg::ST_ADDR && sclFall && byteDone &&
            !startCond && !stopCond && !timedOut &&
            rxShift[7:1] == {`CG_ADDR_FIXED, slaveLsb}
            |=> sdaOe && state == clockgen_pkg::ST_ACK_ADDR;
    endproperty
    a_addrAck: assert property (p_addrAck) // [RULE_03]
        else $error("own address not acknowledged");

    property p_addrMiss;
        state == clockgen_pkg::ST_ADDR && sclFall && byteDone &&
            !startCond && !addrMatch |=> isIdle && !sdaOe;
    endproperty
    a_addrMiss: assert property (p_addrMiss) // [RULE_11]
        else $error("foreign address not ignored");

    property p_outDisable;
        variantSel == clockgen_pkg::VAR_OUTDIS ##1
            variantSel == clockgen_pkg::VAR_OUTDIS
            |-> clkCtrl.enable == !$past(multiFunctionInputA);
    endproperty
    a_outDisable: assert property (p_outDisable) // [RULE_04]
        else $error("output enable does not follow pin");

    property p_highZ;
        outDisable && !driveLowWhenOff |=> clkCtrl.highZ && !clkCtrl.enable;
    endproperty
    a_highZ: assert property (p_highZ) // [RULE_05]
        else $error("disabled outputs not high impedance");

    property p_ptrInc;
        memWe && !stopCond && !startCond && !timedOut
            |=> ptr == $past(ptr) + 8'h01 && mem[$past(ptr)] == $past(rxShift);
    endproperty
    a_ptrInc: assert property (p_ptrInc) // [RULE_09]
        else $error("burst write did not store and advance");

    property p_readStart;
        state == clockgen_pkg::ST_ACK_ADDR && sclFall && rnw &&
            !stopCond && !startCond && !timedOut
            |=> state == clockgen_pkg::ST_READ && txShift == $past(memRdata);
    endproperty
    a_readStart: assert property (p_readStart) // [RULE_10]
        else $error("read did not load addressed register");

    property p_lowVolt;
        memWe && ptr == `CG_REG_LOWVOLT
            |=> lowVoltMode == $past(rxShift[`CG_LOWVOLT_BIT]);
    endproperty
    a_lowVolt: assert property (p_lowVolt) // [RULE_02]
        else $error("low-voltage bit not captured");

    property p_burstRead;
        state == clockgen_pkg::ST_ACK_RD && sclFall && masterAck &&
            !stopCond && !startCond && !timedOut
            |=> state == clockgen_pkg::ST_READ && ptr == $past(ptr) + 8'h01;
    endproperty
    a_burstRead: assert property (p_burstRead) // [RULE_08]
        else $error("burst read did not advance");
endmodule

// *** verif/bus_master.sv ***
// behavioural two-wire bus master on the far side of the serial port
// assumes the bench calls its tasks; sda carries a pull-up
`timescale 1ns/1ps

module bus_master (
    input wire logic mclk,
    input wire logic sdaOe,
    output logic scl,
    output logic sdaIn
);
    logic mLow = 1'b0;
    initial scl = 1'b1;

    // ****
    // wired-and data line, released level is high
    // ****
    assign sdaIn = ~(mLow | sdaOe);

    task automatic hold(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic sStart();
        mLow = 1'b0;
        hold(5);
        scl = 1'b1;
        hold(5);
        mLow = 1'b1;
        hold(5);
        scl = 1'b0;
        hold(5);
    endtask

    task automatic sStop();
        mLow = 1'b1;
        hold(5);
        scl = 1'b1;
        hold(5);
        mLow = 1'b0;
        hold(10);
    endtask

    task automatic bitIo(input logic b, output logic s);
        mLow = ~b;
        hold(5);
        scl = 1'b1;
        hold(5);
        s = sdaIn;
        hold(5);
        scl = 1'b0;
        hold(5);
    endtask

    // bytes msb first, ack read back
    task automatic wrByte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bitIo(d[i], s);
        bitIo(1'b1, s);
        ack = ~s;
    endtask

    // read byte, master ack or nack
    task automatic rdByte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitIo(1'b1, s);
            d[i] = s;
        end
        bitIo(last, s);
    endtask
endmodule

// *** verif/clockgen_serial_ctrl_tb.sv ***
// self-checking bench for the serial port and control pins
// assumes the bus master model drives scl and shares sda
`timescale 1ns/1ps

module clockgen_serial_ctrl_tb;
    localparam int TMO = 200;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    clockgen_pkg::variant_t variantSel = clockgen_pkg::VAR_CLKIN;
    logic multiFunctionInputA = 1'b0;
    logic multiFunctionInputB = 1'b0;
    logic driveLowWhenOff = 1'b0;
    logic scl, sdaIn, sdaOut, sdaOe, lowVoltMode, s;
    clockgen_pkg::clk_ctrl_t clkCtrl;
    clockgen_pkg::clk_ctrl_t ctrlLast = 2'b10;
    clockgen_pkg::step_t phaseStep, freqStep;
    logic [7:0] byteQ[$];
    logic [3:0] stepQ[$];
    logic [1:0] ctrlQ[$];
    logic [7:0] gotByte, devW;
    logic [6:0] addr;
    logic [7:0] dat[7];
    logic [1:0] odIn[5] = '{2'b01, 2'b11, 2'b00, 2'b01, 2'b00};
    event byteEv;
    int n_fail = 0;
    int n_checks = 0;

    initial begin
        forever #20 mclk = ~mclk;
    end

    clockgen_serial_ctrl #(.TIMEOUT_CYCLES(TMO)) u_clockgen_serial_ctrl (
        .mclk,
        .srst,
        .variantSel,
        .multiFunctionInputA,
        .multiFunctionInputB,
        .driveLowWhenOff,
        .scl,
        .sdaIn,
        .sdaOut,
        .sdaOe,
        .clkCtrl,
        .phaseStep,
        .freqStep,
        .lowVoltMode
    );

    bus_master u_bus_master (
        .mclk,
        .sdaOe,
        .scl,
        .sdaIn
    );

    // ****
    // compare and report
    // ****
    task automatic cmpByte(input logic [7:0] e, input logic [7:0] a);
        n_checks++;
        if (a !== e) begin
            n_fail++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, e, a);
        end
    endtask

    task automatic cmpFlag(input logic [3:0] e, input logic [3:0] a);
        n_checks++;
        if (a !== e) begin
            n_fail++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, e, a);
        end
    endtask

    task automatic final_report();
        $display("checks=%0d fails=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ****
    // watchers take the oldest note per result
    // ****
    always @(byteEv) begin
        cmpByte(byteQ.pop_front(), gotByte);
    end

    // outputs are settled at the falling edge
    always @(negedge mclk) begin
        if ({phaseStep, freqStep} != 4'h0) begin
            cmpFlag(stepQ.pop_front(), {phaseStep, freqStep});
        end
        if (!srst && clkCtrl !== ctrlLast) begin
            cmpFlag({2'h0, ctrlQ.pop_front()}, {2'h0, clkCtrl});
        end
        ctrlLast = clkCtrl;
    end

    // ****
    // bus transfers
    // ****
    task automatic wr(input logic [7:0] d, input logic e);
        logic a;
        byteQ.push_back({7'h0, e});
        u_bus_master.wrByte(d, a);
        gotByte = {7'h0, a};
        ->byteEv;
    endtask

    task automatic rd(input logic [7:0] e, input logic last);
        byteQ.push_back(e);
        u_bus_master.rdByte(last, gotByte);
        ->byteEv;
    endtask

    task automatic wrRegs(input logic [7:0] ptr, input int f, input int n);
        u_bus_master.sStart();
        wr(devW, 1'b1);
        wr(ptr, 1'b1);
        for (int i = 0; i < n; i++) begin
            wr(dat[f + i], 1'b1);
        end
        u_bus_master.sStop();
    endtask

    task automatic rdRegs(input logic [7:0] ptr, input int f, input int n,
            input logic setPtr);
        u_bus_master.sStart();
        if (setPtr) begin
            wr(devW, 1'b1);
            wr(ptr, 1'b1);
            u_bus_master.sStart();
        end
        wr(devW | 8'h01, 1'b1);
        for (int i = 0; i < n; i++) begin
            rd(dat[f + i], i == n - 1);
        end
        u_bus_master.sStop();
    endtask

    task automatic pulse(input logic pinB, input int w, input logic [3:0] e);
        if (e != 4'h0) stepQ.push_back(e);
        multiFunctionInputA = ~pinB;
        multiFunctionInputB = pinB;
        repeat (w) @(negedge mclk);
        multiFunctionInputA = 1'b0;
        multiFunctionInputB = 1'b0;
        repeat (8) @(negedge mclk);
    endtask

    // ****
    // main sequence
    // ****
    initial begin
        int w;
        void'($urandom(96089));
        fork
            begin
                repeat (60000) @(posedge mclk);
                n_fail++;
                final_report();
            end
        join_none
        repeat (10) @(negedge mclk);
        srst = 1'b0;
        repeat (2) @(negedge mclk);
        cmpFlag(4'h2, {2'h0, clkCtrl});
        cmpByte(8'h00, {7'h0, lowVoltMode});
        for (int p = 0; p < 2; p++) begin
            multiFunctionInputB = p[0];
            for (int a = 0; a < 3; a++) begin
                addr = (a == 2) ? 7'($urandom_range(63)) : {6'h38, a[0]};
                u_bus_master.sStart();
                wr({addr, 1'b0}, addr == {6'h38, p[0]});
                u_bus_master.sStop();
            end
        end
        devW = 8'he2;
        foreach (dat[i]) dat[i] = 8'($urandom_range(255));
        dat[1] = 8'h80;
        dat[6] = 8'h00;
        wrRegs(8'h1a, 0, 3);
        cmpByte(8'h01, {7'h0, lowVoltMode});
        wrRegs(8'hfe, 3, 3);
        rdRegs(8'hfe, 3, 3, 1'b1);
        rdRegs(8'h00, 6, 1, 1'b0);
        rdRegs(8'h1a, 0, 3, 1'b1);
        u_bus_master.sStart();
        for (int i = 7; i >= 0; i--) u_bus_master.bitIo(devW[i], s);
        cmpByte(8'h01, {7'h0, sdaOe});
        cmpByte(8'h00, {7'h0, sdaOut});
        u_bus_master.hold(TMO + 20);
        cmpByte(8'h00, {7'h0, sdaOe});
        u_bus_master.sStop();
        rdRegs(8'h1c, 2, 1, 1'b1);
        variantSel = clockgen_pkg::VAR_OUTDIS;
        foreach (odIn[k]) begin
            ctrlQ.push_back(odIn[k][0] ? {1'b0, ~odIn[k][1]} : 2'b10);
            driveLowWhenOff = odIn[k][1];
            multiFunctionInputA = odIn[k][0];
            repeat (4) @(negedge mclk);
        end
        variantSel = clockgen_pkg::VAR_CLKIN;
        pulse(1'b0, 6, 4'h0);
        for (int v = 1; v < 3; v++) begin
            variantSel = clockgen_pkg::variant_t'(v);
            for (int b = 0; b < 2; b++) begin
                pulse(b[0], 2, 4'h0);
                pulse(b[0], 3, 4'h8 >> (2 * v - 2 + b));
                w = 3 + $urandom_range(5);
                pulse(b[0], w, 4'h8 >> (2 * v - 2 + b));
            end
        end
        repeat (10) @(negedge mclk);
        cmpByte(8'h00, 8'(byteQ.size() + stepQ.size() + ctrlQ.size()));
        final_report();
    end
endmodule
